// ===== pkg/fcs_pkg.sv
package fcs_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int WAKEUP_DELAY_NS = 600;
    localparam int READ_ACCESS_NS = 150;
    localparam int WAKE_CYCLES = (WAKEUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYCLES = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 4;

    // flash bus widths
    localparam int FLASH_ADDR_W = 17;
    localparam int FLASH_DATA_W = 8;

    // command codes and status bits of the flash
    localparam logic [7:0] READ_ARRAY_CODE = 8'hFF;
    localparam logic [7:0] CLEAR_STATUS_CODE = 8'h50;
    localparam int SR_SUPPLY_ERR_BIT = 3;

    // register port
    localparam int REG_ADDR_W = 3;
    localparam int REG_DATA_W = 32;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_ADDR = 3'h1;
    localparam logic [2:0] REG_WDATA = 3'h2;
    localparam logic [2:0] REG_STATUS = 3'h3;
    localparam logic [2:0] REG_RDATA = 3'h4;

    // control register fields
    localparam int CTRL_READ_BIT = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_SLEEP_BIT = 2;
    localparam int CTRL_WAKE_BIT = 3;
    localparam int CTRL_SUPPLY_BIT = 4;
    localparam int CTRL_STATUS_KIND_BIT = 5;

    // status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_AWAKE_BIT = 1;
    localparam int STAT_LOCK_BIT = 2;
    localparam int STAT_ARRAY_BIT = 3;
    localparam int STAT_REFUSED_BIT = 4;
    localparam int STAT_SUPPLY_BIT = 5;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ASLEEP = 3'b001,
        ST_WAKE = 3'b010,
        ST_WR_SETUP = 3'b011,
        ST_WR_PULSE = 3'b100,
        ST_WR_HOLD = 3'b101,
        ST_RD_ACCESS = 3'b110,
        ST_RD_DONE = 3'b111
    } fcs_state_e;
endpackage

// ===== core/fcs_timer.sv
`timescale 1ns/1ps
module fcs_timer
    import fcs_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // load and expiry
    input wire logic start_in,
    input wire logic [TIMER_W-1:0] count_in,
    output logic done_out
);
    logic [TIMER_W-1:0] count_reg;

    // done rises in the last cycle of the loaded count
    assign done_out = (count_reg == 4'h1);

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            count_reg <= 4'h0;
        end else if (start_in) begin
            count_reg <= count_in;
        end else if (count_reg != 4'h0) begin
            count_reg <= count_reg - 4'h1;
        end
    end
endmodule

// ===== core/fcs_host_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - after supply error, only clear-status or read array until cleared
// - write read array before reading the array
// - writes only with select and strobe both low
// - wait wake-up delay before first access
module fcs_host_ctrl
    import fcs_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [REG_ADDR_W-1:0] reg_addr_in,
    input wire logic [REG_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [REG_DATA_W-1:0] reg_rdata_out,
    // flash pins
    output logic [FLASH_ADDR_W-1:0] flash_addr_out,
    output logic flash_ce_n_out,
    output logic flash_oe_n_out,
    output logic flash_we_n_out,
    output logic power_reset_n_out,
    output logic program_supply_high_out,
    input wire logic [FLASH_DATA_W-1:0] flash_dq_in,
    output logic [FLASH_DATA_W-1:0] flash_dq_out,
    output logic flash_dq_oe_out
);
    fcs_state_e state_reg, state_next;
    logic [FLASH_ADDR_W-1:0] addr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] rdata_reg;
    logic [7:0] byte_reg;
    logic supply_high_reg;
    logic lock_reg;
    logic array_mode_reg;
    logic refused_reg;
    logic status_kind_reg;
    logic read_pend_reg;
    logic ce_n_reg, oe_n_reg, we_n_reg, rst_n_reg, dq_oe_reg;
    logic [REG_DATA_W-1:0] bus_rdata_reg;
    logic timer_start, timer_done;
    logic [TIMER_W-1:0] timer_count;

    function automatic logic in_write(input fcs_state_e s);
        return (s == ST_WR_SETUP) || (s == ST_WR_PULSE) || (s == ST_WR_HOLD);
    endfunction

    // register decode
    wire wr_ctrl = reg_wr_in && (reg_addr_in == REG_CTRL);
    wire wr_addr = reg_wr_in && (reg_addr_in == REG_ADDR);
    wire wr_wdata = reg_wr_in && (reg_addr_in == REG_WDATA);
    wire wr_status = reg_wr_in && (reg_addr_in == REG_STATUS);
    wire go_read = wr_ctrl && reg_wdata_in[CTRL_READ_BIT];
    wire go_write = wr_ctrl && reg_wdata_in[CTRL_WRITE_BIT];
    wire go_sleep = wr_ctrl && reg_wdata_in[CTRL_SLEEP_BIT];
    wire go_wake = wr_ctrl && reg_wdata_in[CTRL_WAKE_BIT];
    wire idle = (state_reg == ST_IDLE);
    // a latched supply error lets only clear-status or read array through
    wire write_blocked = lock_reg && (wdata_reg != CLEAR_STATUS_CODE)
        && (wdata_reg != READ_ARRAY_CODE);
    wire accept_write = idle && go_write && !write_blocked;
    wire accept_read = idle && go_read && !go_write;
    // array reads after any other command need read array first
    wire need_array = accept_read && !reg_wdata_in[CTRL_STATUS_KIND_BIT]
        && !array_mode_reg;
    wire accept_sleep = idle && go_sleep && !go_read && !go_write;
    wire accept_wake = (state_reg == ST_ASLEEP) && go_wake;
    wire refuse_evt = (go_read || go_write || go_sleep || go_wake)
        && !(accept_write || accept_read || accept_sleep || accept_wake);
    wire [7:0] status_byte = {2'b00, supply_high_reg, refused_reg, array_mode_reg, lock_reg,
        (state_reg != ST_ASLEEP), !idle};
    wire [REG_DATA_W-1:0] rd_mux =
        (reg_addr_in == REG_CTRL) ? {26'h0, status_kind_reg, supply_high_reg, 4'h0} :
        (reg_addr_in == REG_ADDR) ? {15'h0, addr_reg} :
        (reg_addr_in == REG_WDATA) ? {24'h0, wdata_reg} :
        (reg_addr_in == REG_STATUS) ? {24'h0, status_byte} :
        (reg_addr_in == REG_RDATA) ? {24'h0, rdata_reg} : 32'h0;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (accept_write || need_array) begin
                    state_next = ST_WR_SETUP;
                end else if (accept_read) begin
                    state_next = ST_RD_ACCESS;
                end else if (accept_sleep) begin
                    state_next = ST_ASLEEP;
                end
            end
            ST_ASLEEP: begin
                if (accept_wake) begin
                    state_next = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (timer_done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_WR_SETUP: state_next = ST_WR_PULSE;
            ST_WR_PULSE: state_next = ST_WR_HOLD;
            ST_WR_HOLD: state_next = read_pend_reg ? ST_RD_ACCESS : ST_IDLE;
            ST_RD_ACCESS: begin
                if (timer_done) begin
                    state_next = ST_RD_DONE;
                end
            end
            ST_RD_DONE: state_next = ST_IDLE;
        endcase
    end

    assign timer_start = (state_next != state_reg)
        && ((state_next == ST_WAKE) || (state_next == ST_RD_ACCESS));
    assign timer_count = (state_next == ST_WAKE) ? TIMER_W'(WAKE_CYCLES) : TIMER_W'(READ_CYCLES);

    fcs_timer u_timer (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .start_in(timer_start),
        .count_in(timer_count),
        .done_out(timer_done)
    );

    // pin levels follow the next state so every pin leaves a flip-flop
    wire ce_n_next = !(in_write(state_next) || (state_next == ST_RD_ACCESS));
    wire we_n_next = (state_next != ST_WR_PULSE);
    wire oe_n_next = (state_next != ST_RD_ACCESS);
    wire rst_n_next = (state_next != ST_ASLEEP);

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_reg <= ST_ASLEEP;
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            rst_n_reg <= 1'b0;
            dq_oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ce_n_reg <= ce_n_next;
            oe_n_reg <= oe_n_next;
            we_n_reg <= we_n_next;
            rst_n_reg <= rst_n_next;
            dq_oe_reg <= in_write(state_next);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            addr_reg <= 17'h0_0000;
            wdata_reg <= 8'h00;
            supply_high_reg <= 1'b0;
            status_kind_reg <= 1'b0;
        end else begin
            if (wr_addr) begin
                addr_reg <= reg_wdata_in[FLASH_ADDR_W-1:0];
            end
            if (wr_wdata) begin
                wdata_reg <= reg_wdata_in[7:0];
            end
            if (wr_ctrl) begin
                supply_high_reg <= reg_wdata_in[CTRL_SUPPLY_BIT];
            end
            if (accept_read) begin
                status_kind_reg <= reg_wdata_in[CTRL_STATUS_KIND_BIT];
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            byte_reg <= 8'h00;
            read_pend_reg <= 1'b0;
            array_mode_reg <= 1'b1;
            lock_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else if (accept_sleep) begin
            // flash comes back in read array with a fresh status
            array_mode_reg <= 1'b1;
            lock_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && state_next == ST_WR_SETUP) begin
            byte_reg <= need_array ? READ_ARRAY_CODE : wdata_reg;
            read_pend_reg <= need_array;
            array_mode_reg <= need_array || (wdata_reg == READ_ARRAY_CODE);
            if (!need_array && wdata_reg == CLEAR_STATUS_CODE) begin
                lock_reg <= 1'b0;
            end
        end else if (state_reg == ST_RD_ACCESS && timer_done) begin
            rdata_reg <= flash_dq_in;
            read_pend_reg <= 1'b0;
            if (status_kind_reg && flash_dq_in[SR_SUPPLY_ERR_BIT]) begin
                lock_reg <= 1'b1;
            end
        end
    end

    // refused flag: a new refusal wins over a clear in the same cycle
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            refused_reg <= 1'b0;
        end else if (refuse_evt) begin
            refused_reg <= 1'b1;
        end else if (wr_status && reg_wdata_in[STAT_REFUSED_BIT]) begin
            refused_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            bus_rdata_reg <= 32'h0;
        end else begin
            bus_rdata_reg <= reg_rd_in ? rd_mux : 32'h0;
        end
    end

    assign reg_rdata_out = bus_rdata_reg;
    assign flash_addr_out = addr_reg;
    assign flash_ce_n_out = ce_n_reg;
    assign flash_oe_n_out = oe_n_reg;
    assign flash_we_n_out = we_n_reg;
    assign power_reset_n_out = rst_n_reg;
    assign program_supply_high_out = supply_high_reg;
    assign flash_dq_out = byte_reg;
    assign flash_dq_oe_out = dq_oe_reg;

    property p_write_needs_select;
        @(posedge core_clk_in) disable iff (rst_in)
        !flash_we_n_out |-> !flash_ce_n_out && flash_oe_n_out && flash_dq_oe_out
            && $past(!flash_ce_n_out) ##1 flash_we_n_out && !flash_ce_n_out;
    endproperty
    a_write_needs_select: assert property (p_write_needs_select)
        else $error("write strobe low without chip select framing");

    property p_lock_blocks;
        @(posedge core_clk_in) disable iff (rst_in)
        $fell(flash_we_n_out) && $past(lock_reg, 2) |->
            (flash_dq_out == CLEAR_STATUS_CODE) || (flash_dq_out == READ_ARRAY_CODE);
    endproperty
    a_lock_blocks: assert property (p_lock_blocks)
        else $error("command written while supply error latched");

    property p_wake_wait;
        @(posedge core_clk_in) disable iff (rst_in)
        $rose(power_reset_n_out) |-> flash_ce_n_out [*6] ##1 (state_reg == ST_IDLE);
    endproperty
    a_wake_wait: assert property (p_wake_wait)
        else $error("access started before wake-up delay");

    property p_asleep_quiet;
        @(posedge core_clk_in) disable iff (rst_in)
        !power_reset_n_out |-> flash_ce_n_out && flash_we_n_out && flash_oe_n_out;
    endproperty
    a_asleep_quiet: assert property (p_asleep_quiet)
        else $error("flash selected while held in reset");

    property p_array_read_mode;
        @(posedge core_clk_in) disable iff (rst_in)
        $fell(flash_oe_n_out) && !status_kind_reg |-> array_mode_reg;
    endproperty
    a_array_read_mode: assert property (p_array_read_mode)
        else $error("array read without read array mode");
endmodule

// ===== testbench/fcs_flash_model.sv
`timescale 1ns/1ps
module fcs_flash_model
    import fcs_pkg::*;
(
    // flash pins
    input wire logic [FLASH_ADDR_W-1:0] addr_in,
    input wire logic ce_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic power_reset_n_in,
    input wire logic supply_high_in,
    input wire logic [FLASH_DATA_W-1:0] dq_in,
    output logic [FLASH_DATA_W-1:0] dq_out,
    // internal state for the bench
    output logic [7:0] cmd_out,
    output logic [7:0] sr_out
);
    logic [7:0] last_reg = 8'h00;
    logic awake_reg = 1'b0;
    logic setup_reg = 1'b0;
    logic erase_reg = 1'b0;
    initial cmd_out = 8'hFF;
    initial sr_out = 8'h80;
    // outputs stay invalid until the wake-up delay has run out
    always @(power_reset_n_in) begin
        awake_reg = 1'b0;
        if (power_reset_n_in) awake_reg <= #(WAKEUP_DELAY_NS) 1'b1;
    end
    always @(negedge power_reset_n_in) begin
        cmd_out = 8'hFF;
        sr_out = 8'h80;
        setup_reg = 1'b0;
    end
    always @(posedge we_n_in) begin
        if (power_reset_n_in && !ce_n_in) begin
            cmd_out = dq_in;
            if (setup_reg) begin
                setup_reg = 1'b0;
                cmd_out = 8'h70;
                // a low supply or a pending supply error inhibits the change
                if (!supply_high_in || sr_out[3]) sr_out[3] = 1'b1;
                sr_out[7] = 1'b1;
                // an erase setup without its confirm flags both errors
                if (erase_reg && dq_in != 8'hD0) sr_out[5:4] = 2'b11;
            end else if (dq_in == 8'h40 || dq_in == 8'h20) begin
                setup_reg = 1'b1;
                erase_reg = (dq_in == 8'h20);
            end else if (dq_in == CLEAR_STATUS_CODE) begin
                sr_out = 8'h80;
            end
        end
    end
    // a released bus shows the inverse of the last byte, never a held value
    always @* begin
        if (!ce_n_in && !oe_n_in && power_reset_n_in && awake_reg) begin
            dq_out = (cmd_out == 8'hFF) ? (addr_in[7:0] ^ 8'h5A) : sr_out;
            last_reg = dq_out;
        end else begin
            dq_out = ~last_reg;
        end
    end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench
    import fcs_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [31:0] wdata = 32'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [31:0] rdata;
    logic [16:0] f_addr;
    logic ce_n, oe_n, we_n, prn, sup, dq_oe;
    logic [7:0] dq_h2f, dq_f2h, m_cmd, m_sr;
    logic [31:0] v;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #50 clk = ~clk;
    fcs_host_ctrl dut (.core_clk_in(clk), .rst_in(rst), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
        .flash_addr_out(f_addr), .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n),
        .flash_we_n_out(we_n), .power_reset_n_out(prn), .program_supply_high_out(sup),
        .flash_dq_in(dq_f2h), .flash_dq_out(dq_h2f), .flash_dq_oe_out(dq_oe));
    fcs_flash_model flash (.addr_in(f_addr), .ce_n_in(ce_n), .oe_n_in(oe_n),
        .we_n_in(we_n), .power_reset_n_in(prn), .supply_high_in(sup),
        .dq_in(dq_oe ? dq_h2f : ~dq_h2f), .dq_out(dq_f2h), .cmd_out(m_cmd), .sr_out(m_sr));
    task automatic test_done;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            test_done;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask
    // polls busy under a bound and leaves the last status word in v
    task automatic idle;
        int i;
        v = 32'h1;
        for (i = 0; i < 30 && v[STAT_BUSY_BIT] !== 1'b0; i++) rd(REG_STATUS, v);
        if (i == 30) chk(v, 32'h0);
    endtask
    task automatic st(input logic [31:0] e);
        idle;
        chk(v, e);
    endtask
    task automatic cmd(input logic [7:0] b);
        wr(REG_WDATA, {24'h0, b});
        wr(REG_CTRL, 32'h2);
        idle;
    endtask
    task automatic t_reset;
        chk(prn, 1'b0);
        chk(m_cmd, 8'hFF);
        // busy stays high while the flash sleeps, so no polling here
        rd(REG_STATUS, v);
        chk(v, 32'h09);
    endtask
    task automatic t_wake;
        int i;
        wr(REG_CTRL, 32'h8);
        for (i = 0; i < 6; i++) begin
            @(posedge clk);
            #1 chk(ce_n, 1'b1);
        end
        st(32'h0A);
        chk(prn, 1'b1);
    endtask
    task automatic t_supply_err;
        cmd(8'h40);
        cmd(8'h11);
        chk(m_sr, 8'h88);
        wr(REG_CTRL, 32'h21);
        idle;
        rd(REG_RDATA, v);
        chk(v, 32'h88);
        st(32'h06);
        cmd(8'h40);
        st(32'h16);
        chk(m_cmd, 8'h70);
        wr(REG_STATUS, 32'h10);
        cmd(CLEAR_STATUS_CODE);
        st(32'h02);
        chk(m_sr, 8'h80);
    endtask
    task automatic t_array;
        wr(REG_ADDR, 32'h12345);
        wr(REG_CTRL, 32'h1);
        st(32'h0A);
        chk(m_cmd, 8'hFF);
        rd(REG_RDATA, v);
        chk(v, 32'h1F);
        rd(3'h7, v);
        chk(v, 32'h0);
    endtask
    task automatic t_supply_ok;
        wr(REG_WDATA, 32'h40);
        wr(REG_CTRL, 32'h12);
        idle;
        wr(REG_WDATA, 32'h22);
        wr(REG_CTRL, 32'h12);
        st(32'h22);
        chk(m_sr, 8'h80);
        wr(REG_WDATA, 32'h20);
        wr(REG_CTRL, 32'h12);
        idle;
        wr(REG_WDATA, 32'h00);
        wr(REG_CTRL, 32'h12);
        idle;
        chk(m_sr, 8'hB0);
        rd(REG_CTRL, v);
        chk(v, 32'h10);
        @(posedge clk);
        #1 chk(rdata, 32'h0);
    endtask
    task automatic t_sleep;
        cmd(8'h40);
        wr(REG_CTRL, 32'h4);
        rd(REG_STATUS, v);
        chk(v, 32'h09);
        chk(prn, 1'b0);
        chk(m_sr, 8'h80);
        chk(m_cmd, 8'hFF);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_wake;
        t_supply_err;
        t_array;
        t_supply_ok;
        t_sleep;
        t_wake;
        t_array;
        test_done;
    end
endmodule
